//--- design/etp_counter.sv
// 8-bit count core with clear-and-start and free-running modes
`timescale 1ns/1ps
module etp_counter #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // control
    input wire logic run_in,
    input wire logic count_tick_in,
    input wire etp_pkg::etp_mode_type mode_in,
    input wire logic [WIDTH-1:0] compare_in,
    // state
    output logic [WIDTH-1:0] count_out,
    output logic match_out,
    output logic wrap_out
);
    import etp_pkg::*;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire logic at_compare; // counter equals compare value
    wire logic at_top; // counter at its last value, wraps next
    logic [WIDTH-1:0] next_count; // counter value for the next edge

    assign at_compare = (count_out == compare_in);
    assign at_top = (count_out == {WIDTH{1'b1}});
    assign match_out = run_in && count_tick_in && at_compare;
    assign wrap_out = run_in && count_tick_in && at_top;

    // next counter value by mode
    always_comb begin
        next_count = count_out;
        if (!run_in) begin
            next_count = '0;
        end else if (count_tick_in) begin
            if (mode_in == ETP_MODE_CLEAR_START && at_compare) begin
                next_count = '0;
            end else begin
                next_count = count_out + 1'b1;
            end
        end
    end

    // counter register, frozen while clock enable is low
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (clk_en_in) begin
            count_out <= next_count;
        end
    end
endmodule : etp_counter

//--- design/etp_output.sv
// timer output flip-flop, pwm level and output enable gate
`timescale 1ns/1ps
module etp_output (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // control
    input wire etp_pkg::etp_mode_type mode_in,
    input wire logic run_in,
    input wire logic ff_ctrl_in,
    input wire logic out_en_in,
    input wire logic preset_set_in,
    input wire logic preset_clr_in,
    input wire logic match_in,
    input wire logic wrap_in,
    input wire logic [7:0] count_in,
    input wire logic [7:0] compare_in,
    // timer output
    output logic timer_out
);
    import etp_pkg::*;

    // ------------------------------------------------------------
    // flip-flop and pwm state
    // ------------------------------------------------------------
    logic out_ff; // toggling output flip-flop
    logic next_out_ff;
    wire logic pwm_mode; // pwm counting selected
    wire logic pwm_active; // pwm in its active phase
    wire logic pwm_level; // pwm after level selection
    wire logic raw_out; // source before the enable gate

    assign pwm_mode = (mode_in == ETP_MODE_PWM);
    // active from wrap until compare; a compare of zero gives no active time
    assign pwm_active = run_in && (count_in < compare_in);
    assign pwm_level = ff_ctrl_in ? !pwm_active : pwm_active;
    // combinational from the register bits so changes act at once
    assign raw_out = pwm_mode ? pwm_level : out_ff;
    assign timer_out = out_en_in && raw_out;

    // preset wins over toggle; both presets set is treated as no preset, so a match can still toggle
    always_comb begin
        next_out_ff = out_ff;
        if (!pwm_mode && preset_clr_in && !preset_set_in) begin
            next_out_ff = 1'b0;
        end else if (!pwm_mode && preset_set_in && !preset_clr_in) begin
            next_out_ff = 1'b1;
        end else if (!pwm_mode && ff_ctrl_in && match_in) begin
            next_out_ff = !out_ff;
        end
    end

    // output flip-flop register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            out_ff <= 1'b0;
        end else if (clk_en_in) begin
            out_ff <= next_out_ff;
        end
    end

    // wrap is only informative here
    wire logic unused_wrap;
    assign unused_wrap = wrap_in;
endmodule : etp_output

//--- design/etp_pkg.sv
// package: register map, field positions and reset values for the 8-bit timer block
package etp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ETP_MODE_CTRL_ADDR = 16'hff43; // timer_mode_control
    localparam logic [15:0] ETP_COMPARE_ADDR = 16'hff44;   // compare value register
    localparam logic [15:0] ETP_COUNTER_ADDR = 16'hff45;   // counter readback
    localparam logic [15:0] ETP_PORT_CTRL_ADDR = 16'hff46; // port direction and latch
    // ------------------------------------------------------------
    // field positions in timer_mode_control
    // ------------------------------------------------------------
    localparam int ETP_BIT_OUT_EN = 0;   // output_enable_bit
    localparam int ETP_BIT_FF_CTRL = 1;  // flipflop_control_bit
    localparam int ETP_BIT_PRE_CLR = 2;  // flipflop_preset_clear
    localparam int ETP_BIT_PRE_SET = 3;  // flipflop_preset_set
    localparam int ETP_BIT_MODE = 6;     // mode_select_bit
    localparam int ETP_BIT_CNT_EN = 7;   // count_enable_bit
    // ------------------------------------------------------------
    // field positions in port control register
    // ------------------------------------------------------------
    localparam int ETP_BIT_PORT_DIR = 0; // port_direction_bit, 1 = input
    localparam int ETP_BIT_PORT_LAT = 1; // port_latch_bit
    // ------------------------------------------------------------
    // reset values, read and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] ETP_MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] ETP_COMPARE_RESET = 8'h00;
    localparam logic [1:0] ETP_PORT_CTRL_RESET = 2'h1;
    localparam logic [7:0] ETP_MODE_CTRL_RMASK = 8'hc3; // preset bits and 5:4 read zero
    localparam logic [7:0] ETP_MODE_CTRL_WMASK = 8'hcf;
    localparam logic [7:0] ETP_COUNT_ZERO = 8'h00;
    // ------------------------------------------------------------
    // counting modes
    // ------------------------------------------------------------
    typedef enum logic {ETP_MODE_CLEAR_START, ETP_MODE_PWM} etp_mode_type;
endpackage : etp_pkg

//--- design/etp_timer.sv
// top of the 8-bit timer with pwm: register port, counter and output
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Contract
// - count enable low clears and stops counter
// - mode bit picks clear-start or pwm
// - preset bits clear or set output flip-flop
// - control bit enables toggling outside pwm
// - control bit selects pwm active level
// - output enable low holds output low
// - preset bits are write-only, read zero
// - presets ignored in pwm mode
// - stopping pwm forces output inactive
// - control bits reach output immediately
// - pin level uses direction and latch
module etp_timer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // count clock tick from prescaler
    input wire logic count_tick_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // shared pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    // internal timer output
    output logic timer_out
);
    import etp_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] timer_mode_control; // stored mode bits, preset bits never stored
    logic [7:0] compare_value; // compare register
    logic [1:0] port_ctrl; // direction and latch
    logic preset_set_pulse; // one-cycle preset request
    logic preset_clr_pulse;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic sel_mode = (reg_addr_in == ETP_MODE_CTRL_ADDR);
    wire logic sel_cmp = (reg_addr_in == ETP_COMPARE_ADDR);
    wire logic sel_cnt = (reg_addr_in == ETP_COUNTER_ADDR);
    wire logic sel_port = (reg_addr_in == ETP_PORT_CTRL_ADDR);
    wire logic wr_mode = reg_wr_in && sel_mode;
    wire logic [7:0] count_value;
    wire logic match_evt;
    wire logic wrap_evt;
    wire logic run = timer_mode_control[ETP_BIT_CNT_EN];
    wire etp_mode_type mode = timer_mode_control[ETP_BIT_MODE] ? ETP_MODE_PWM
                                                               : ETP_MODE_CLEAR_START;

    // read data mux; unmapped reads return zero
    always_comb begin
        next_rdata = 8'h00;
        if (sel_mode) begin
            next_rdata = timer_mode_control & ETP_MODE_CTRL_RMASK;
        end else if (sel_cmp) begin
            next_rdata = compare_value;
        end else if (sel_cnt) begin
            next_rdata = count_value;
        end else if (sel_port) begin
            next_rdata = {6'h00, port_ctrl};
        end
    end

    // register writes; order and stability are left to software
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            timer_mode_control <= ETP_MODE_CTRL_RESET;
            compare_value <= ETP_COMPARE_RESET;
            port_ctrl <= ETP_PORT_CTRL_RESET;
        end else if (clk_en_in) begin
            if (wr_mode) begin
                timer_mode_control <= reg_wdata_in & ETP_MODE_CTRL_RMASK;
            end
            if (reg_wr_in && sel_cmp) begin
                compare_value <= reg_wdata_in;
            end
            if (reg_wr_in && sel_port) begin
                port_ctrl <= reg_wdata_in[1:0];
            end
        end
    end

    // preset requests live for one cycle after the write
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            preset_set_pulse <= 1'b0;
            preset_clr_pulse <= 1'b0;
        end else if (clk_en_in) begin
            preset_set_pulse <= wr_mode && reg_wdata_in[ETP_BIT_PRE_SET];
            preset_clr_pulse <= wr_mode && reg_wdata_in[ETP_BIT_PRE_CLR];
        end
    end

    // read data register, valid the cycle after the strobe only
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (clk_en_in) begin
            reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    etp_counter #(
        .WIDTH(WIDTH)
    ) u_counter (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .run_in(run),
        .count_tick_in(count_tick_in),
        .mode_in(mode),
        .compare_in(compare_value),
        .count_out(count_value),
        .match_out(match_evt),
        .wrap_out(wrap_evt)
    );

    etp_output u_output (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .mode_in(mode),
        .run_in(run),
        .ff_ctrl_in(timer_mode_control[ETP_BIT_FF_CTRL]),
        .out_en_in(timer_mode_control[ETP_BIT_OUT_EN]),
        .preset_set_in(preset_set_pulse),
        .preset_clr_in(preset_clr_pulse),
        .match_in(match_evt),
        .wrap_in(wrap_evt),
        .count_in(count_value),
        .compare_in(compare_value),
        .timer_out(timer_out)
    );

    // ------------------------------------------------------------
    // pin shaping
    // ------------------------------------------------------------
    // output mode drives latch and timer combined; input mode releases pin
    assign pin_oe_out = !port_ctrl[ETP_BIT_PORT_DIR];
    assign pin_out = port_ctrl[ETP_BIT_PORT_LAT] | timer_out;

    // pin input is not used by this block
    wire logic unused_pin;
    assign unused_pin = pin_in;
endmodule : etp_timer

//--- tb/etp_pin_load.sv
// far-side model: load on the shared timer pin
`timescale 1ns/1ps
module etp_pin_load (
    // drive from the block
    input wire logic drv_in,
    input wire logic oe_in,
    // resolved wire level
    output logic lvl_out
);
    // released pin goes to the pull-up level, never the last driven value
    assign lvl_out = oe_in ? drv_in : 1'b1;
endmodule : etp_pin_load

//--- tb/etp_timer_properties.sv
// checker: port-level properties of the 8-bit timer
`timescale 1ns/1ps
module etp_timer_properties
    import etp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic count_tick_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // pin side
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe_out,
    input wire logic timer_out
);
    // shadows rebuilt from the write strobes, since the body is hidden
    logic [7:0] mode_sh;
    logic [1:0] port_sh;
    wire logic wr_mode = reg_wr_in && clk_en_in && reg_addr_in == ETP_MODE_CTRL_ADDR;
    wire logic wr_port = reg_wr_in && clk_en_in && reg_addr_in == ETP_PORT_CTRL_ADDR;
    wire logic rd_go = reg_rd_in && clk_en_in;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mode_sh <= ETP_MODE_CTRL_RESET;
            port_sh <= ETP_PORT_CTRL_RESET;
        end else begin
            if (wr_mode) mode_sh <= reg_wdata_in & ETP_MODE_CTRL_WMASK;
            if (wr_port) port_sh <= reg_wdata_in[1:0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    a_mode_readback: assert property (
        rd_go && reg_addr_in == ETP_MODE_CTRL_ADDR
        |=> reg_rdata_out == ($past(mode_sh) & ETP_MODE_CTRL_RMASK)) else $error("mode readback");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    a_out_disabled: assert property (!mode_sh[0] |-> !timer_out)
        else $error("output not held low");
    a_pwm_idle_level: assert property (
        mode_sh[6] && !mode_sh[7] && mode_sh[0] |-> timer_out == mode_sh[1])
        else $error("stopped pwm not inactive");
    a_stop_count: assert property (
        rd_go && reg_addr_in == ETP_COUNTER_ADDR && !mode_sh[7] && !$past(mode_sh[7])
        |=> reg_rdata_out == 8'h00) else $error("stopped counter not zero");
    a_preset_set: assert property (
        wr_mode && reg_wdata_in[3:2] == 2'b10 && reg_wdata_in[0] && !reg_wdata_in[6]
        && !reg_wdata_in[7] |-> ##2 timer_out) else $error("preset set lost");
    a_dir_oe: assert property (pin_oe_out == !port_sh[0])
        else $error("pin enable wrong");
    a_pin_mix: assert property (pin_out == (port_sh[1] | timer_out))
        else $error("pin level wrong");
endmodule : etp_timer_properties
bind etp_timer etp_timer_properties #(.WIDTH(WIDTH)) u_chk (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .clk_en_in(clk_en_in), .count_tick_in(count_tick_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out), .timer_out(timer_out));

//--- tb/etp_timer_tb_top.sv
// testbench: register-driven scenarios for the 8-bit timer
`timescale 1ns/1ps
module etp_timer_tb_top;
    import etp_pkg::*;
    // ----
    // stimulus and observed signals
    // ----
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1; // clock enable, dropped once to prove the freeze
    logic [7:0] rdata;
    logic lvl, drv, oe, tmr;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 clk = ~clk;
    etp_timer #(.WIDTH(8)) u_dut (.clk_sys_in(clk), .rst_in(rst), .clk_en_in(ce),
        .count_tick_in(tick), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .pin_in(lvl), .pin_out(drv),
        .pin_oe_out(oe), .timer_out(tmr));
    etp_pin_load u_load (.drv_in(drv), .oe_in(oe), .lvl_out(lvl));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one-cycle write strobe, master waits for nothing
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask : rd_chk
    // presets land two edges after the write, so settle that long
    task automatic out_chk(input string nm, input logic e);
        repeat (2) @(posedge clk);
        #1 chk(nm, {7'h00, e}, {7'h00, tmr});
    endtask : out_chk
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask : ticks
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // watchdog: the sequence needs under 2000 cycles
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk("mode", ETP_MODE_CTRL_ADDR, 8'h00);
        rd_chk("compare", ETP_COMPARE_ADDR, 8'h00);
        rd_chk("port", ETP_PORT_CTRL_ADDR, 8'h01);
        rd_chk("unmapped", 16'hff47, 8'h00);
        // clear-and-start, compare 3, toggling on
        wr_reg(ETP_COMPARE_ADDR, 8'h03);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h02);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h03);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h0b);
        out_chk("preset set", 1'b1);
        rd_chk("preset read", ETP_MODE_CTRL_ADDR, 8'h03);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h07);
        out_chk("preset clr", 1'b0);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h0b);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h83);
        ticks(3);
        rd_chk("count", ETP_COUNTER_ADDR, 8'h03);
        ticks(1);
        rd_chk("match clear", ETP_COUNTER_ADDR, 8'h00);
        out_chk("toggle", 1'b0);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h03);
        ticks(2);
        rd_chk("stopped", ETP_COUNTER_ADDR, 8'h00);
        // pwm, compare 2
        wr_reg(ETP_COMPARE_ADDR, 8'h02);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h40);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h41);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h49);
        out_chk("pwm preset", 1'b0);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'hc1);
        out_chk("pwm on", 1'b1);
        ticks(2);
        out_chk("pwm off", 1'b0);
        // clock enable low must hold the counter through three ticks
        @(posedge clk);
        ce <= 1'b0;
        ticks(3);
        ce <= 1'b1;
        rd_chk("frozen", ETP_COUNTER_ADDR, 8'h02);
        ticks(254);
        out_chk("pwm wrap", 1'b1);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h41);
        out_chk("pwm stop", 1'b0);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h43);
        out_chk("low idle", 1'b1);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'hc3);
        out_chk("low on", 1'b0);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h43);
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h42);
        out_chk("out off", 1'b0);
        // back to clear-start: the preset set written in pwm must not have landed
        wr_reg(ETP_MODE_CTRL_ADDR, 8'h03);
        out_chk("pwm preset kept", 1'b0);
        wr_reg(ETP_PORT_CTRL_ADDR, 8'h02);
        #1 chk("pin", 8'h01, {7'h00, lvl});
        close_out();
    end
endmodule : etp_timer_tb_top
